// File: include/sfcd_pkg.sv
// Purpose: Shared constants for the serial flash command decoder
// Assumes: Serial pins sampled synchronously on i_clk
// Notes: Command codes, phase lengths and reset values
package sfcd_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST_READ = 8'h0B;
  localparam logic [7:0] CMD_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] CMD_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] CMD_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] CMD_PAGE_WRITE = 8'h02;
  localparam logic [7:0] CMD_QUAD_PAGE_WRITE = 8'h38;
  localparam logic [7:0] CMD_WIPE_4K = 8'h20;
  localparam logic [7:0] CMD_WIPE_32K = 8'h52;
  localparam logic [7:0] CMD_WIPE_64K = 8'hD8;
  localparam logic [7:0] CMD_WIPE_ALL_A = 8'h60;
  localparam logic [7:0] CMD_WIPE_ALL_B = 8'hC7;
  localparam logic [7:0] CMD_PARAM_TABLE_READ = 8'h5A;
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'h06;
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_CONFIG_READ = 8'h15;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAUSE_A = 8'h75;
  localparam logic [7:0] CMD_PAUSE_B = 8'hB0;
  localparam logic [7:0] CMD_CONTINUE_A = 8'h7A;
  localparam logic [7:0] CMD_CONTINUE_B = 8'h30;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] CMD_BURST_LENGTH = 8'hC0;

  // ==========================================================================
  // Phase lengths and burst length reset value
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [2:0] QUAD_DUMMY_CLKS = 3'h6;
  localparam logic [1:0] STATUS_WRITE_MAX = 2'h3;
  localparam logic [7:0] BURST_LEN_RST = 8'h00;

  // ==========================================================================
  // Decoded operations
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_READ = 5'h01,
    OP_FAST_READ = 5'h02,
    OP_DUAL_IO_READ = 5'h03,
    OP_DUAL_OUT_READ = 5'h04,
    OP_QUAD_IO_READ = 5'h05,
    OP_QUAD_OUT_READ = 5'h06,
    OP_PAGE_WRITE = 5'h07,
    OP_QUAD_PAGE_WRITE = 5'h08,
    OP_WIPE_4K = 5'h09,
    OP_WIPE_32K = 5'h0A,
    OP_WIPE_64K = 5'h0B,
    OP_WIPE_ALL = 5'h0C,
    OP_PARAM_TABLE_READ = 5'h0D,
    OP_WRITE_UNLOCK = 5'h0E,
    OP_WRITE_LOCK = 5'h0F,
    OP_STATUS_READ = 5'h10,
    OP_CONFIG_READ = 5'h11,
    OP_STATUS_WRITE = 5'h12,
    OP_PAUSE = 5'h13,
    OP_CONTINUE = 5'h14,
    OP_DEEP_SLEEP = 5'h15,
    OP_BURST_LENGTH = 5'h16
  } sfcd_op_e;

  // Frame phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_CMD = 3'h1,
    PH_ADDR = 3'h2,
    PH_DUMMY = 3'h3,
    PH_VALUE = 3'h4,
    PH_DATA = 3'h5,
    PH_DONE = 3'h6,
    PH_REJECT = 3'h7
  } sfcd_phase_e;

endpackage : sfcd_pkg

// File: sim/sfcd_checker.sv
// Purpose: Port checker for the serial flash command decoder
// Assumes: One clock domain, reset asynchronous active low
// Notes: Attached by bind below the module
module sfcd_checker
  import sfcd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_cs_n,
  input wire logic i_op_busy,
  input wire logic o_cmd_valid,
  input wire sfcd_pkg::sfcd_op_e o_op,
  input wire logic [1:0] o_lane_log2,
  input wire logic o_out_data,
  input wire logic o_exec,
  input wire logic o_reject,
  input wire logic o_write_unlock_flag,
  input wire logic o_paused,
  input wire logic o_sio_drive,
  input wire logic o_standby
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Clocking and frame sequences
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_cs_rise;
    !i_cs_n ##1 i_cs_n;
  endsequence

  sequence s_unlock_done;
    o_exec && o_op == OP_WRITE_UNLOCK;
  endsequence

  // ==========================================================================
  // Properties
  a_cmd_one_cycle: assert property (o_cmd_valid |=> !o_cmd_valid)
    else $error("command pulse held");
  a_exec_after_cs: assert property (o_exec |-> $past(i_cs_n))
    else $error("exec without select release");
  a_exec_rej_excl: assert property (!(o_exec && o_reject))
    else $error("exec and reject together");
  a_unlock_sets: assert property (s_unlock_done |-> o_write_unlock_flag)
    else $error("unlock flag not set");
  a_lock_clears: assert property (o_exec && o_op == OP_WRITE_LOCK |-> !o_write_unlock_flag)
    else $error("unlock flag not cleared");
  a_quad_lanes: assert property (o_out_data && (o_op == OP_QUAD_IO_READ ||
    o_op == OP_QUAD_OUT_READ) |-> o_lane_log2 == 2'h2)
    else $error("quad read not four lanes");
  a_dual_lanes: assert property (o_out_data && (o_op == OP_DUAL_IO_READ ||
    o_op == OP_DUAL_OUT_READ) |-> o_lane_log2 == 2'h1)
    else $error("dual read not two lanes");
  a_single_lane: assert property (o_out_data && (o_op == OP_READ ||
    o_op == OP_FAST_READ) |-> o_lane_log2 == 2'h0)
    else $error("single read not one lane");
  a_standby_quiet: assert property (o_standby |-> !o_sio_drive)
    else $error("drive during standby");
  a_drive_release: assert property (s_cs_rise |-> ##[1:3] !o_sio_drive)
    else $error("drive kept after select release");
  a_pause_busy: assert property ($rose(o_paused) |-> $past(i_op_busy))
    else $error("pause without busy engine");
  a_pause_flag: assert property ($rose(o_paused) |-> ##[0:1] !o_write_unlock_flag)
    else $error("pause kept unlock flag");
endmodule : sfcd_checker

bind sfcd_decoder sfcd_checker u_chk (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_cs_n(i_cs_n),
  .i_op_busy(i_op_busy), .o_cmd_valid(o_cmd_valid), .o_op(o_op), .o_lane_log2(o_lane_log2),
  .o_out_data(o_out_data), .o_exec(o_exec), .o_reject(o_reject),
  .o_write_unlock_flag(o_write_unlock_flag), .o_paused(o_paused),
  .o_sio_drive(o_sio_drive), .o_standby(o_standby));

// File: sim/sfcd_decoder_bench.sv
// Purpose: Self-checking bench of the serial flash command decoder
// Assumes: Host model drives the serial side at the falling edge
// Notes: Driver notes results in a queue, monitor compares
module sfcd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import sfcd_pkg::*;

  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic op_done = 1'b0;
  logic op_busy = 1'b0;
  logic sclk, cs_n, cmd_valid, in_data, out_data, addr_valid, value_valid;
  logic exec, reject, unlock, paused, sleep, drive, standby;
  logic [3:0] sio;
  logic [1:0] lane, vidx;
  logic [23:0] addr;
  logic [7:0] value, burst;
  sfcd_op_e op;
  int err_count = 0;
  int total_checks = 0;
  int tn = 0;
  logic [31:0] seed = 32'hC4DC10F0;
  logic [31:0] exp_q[$];
  logic av_q = 1'b0;
  logic [15:0] tbl [0:23] = '{16'h0301, 16'h0B02, 16'hBB03, 16'h3B04, 16'hEB05, 16'h6B06,
    16'h5A0D, 16'h0510, 16'h1511, 16'h0247, 16'h3848, 16'h2049, 16'h524A, 16'hD84B,
    16'h0152, 16'hC056, 16'h604C, 16'h7593, 16'hB093, 16'h7A94, 16'h3094, 16'h048F,
    16'h068E, 16'hC78C};
  logic [7:0] rc [0:3] = '{8'h03, 8'h0B, 8'hBB, 8'hEB};
  sfcd_op_e ro [0:3] = '{OP_READ, OP_FAST_READ, OP_DUAL_IO_READ, OP_QUAD_IO_READ};
  int ra [0:3] = '{0, 0, 1, 2};
  int rdm [0:3] = '{0, 8, 4, 6};

  // ==========================================================================
  // Clock, host and design
  always #5 clk = ~clk;

  sfcd_host host (.i_clk(clk), .o_sclk(sclk), .o_cs_n(cs_n), .o_sio(sio));

  sfcd_decoder DUT (.i_clk(clk), .i_arst_n(arst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_sio(sio), .i_op_done(op_done), .i_op_busy(op_busy), .o_cmd_valid(cmd_valid),
    .o_op(op), .o_lane_log2(lane), .o_in_data(in_data), .o_out_data(out_data),
    .o_addr(addr), .o_addr_valid(addr_valid), .o_value(value),
    .o_value_valid(value_valid), .o_value_idx(vidx), .o_exec(exec), .o_reject(reject),
    .o_write_unlock_flag(unlock), .o_paused(paused), .o_deep_sleep(sleep),
    .o_burst_len(burst), .o_sio_drive(drive), .o_standby(standby));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic check1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask : check1

  task automatic seen(input logic [31:0] got);
    logic [31:0] e;
    e = 32'hFFFFFFFF;
    if (exp_q.size() > 0) e = exp_q.pop_front();
    check(got, e);
  endtask : seen

  task automatic note(input logic [3:0] k, input logic [27:0] d);
    exp_q.push_back({k, d});
  endtask : note

  task automatic cmd(input logic [7:0] c);
    host.sel();
    host.shift(c, 0, 8);
  endtask : cmd

  task automatic addr3(input logic [23:0] a, input int lg);
    for (int b = 2; b >= 0; b--) host.shift(a[b * 8 +: 8], lg, 8 >> lg);
  endtask : addr3

  // Command alone: op note, then exec or reject note if any
  task automatic simple(input logic [15:0] t);
    note(4'h1, 28'(t[4:0]));
    if (t[7:6] != 2'b00) note(4'h2, 28'(t[7:6]));
    cmd(t[15:8]);
    host.rel();
  endtask : simple

  task automatic pulse_done();
    op_done = 1'b1;
    @(negedge clk);
    op_done = 1'b0;
    @(negedge clk);
  endtask : pulse_done

  task automatic tdone();
    tn++;
    $display("test %0d done", tn);
  endtask : tdone

  task automatic print_verdict();
    if (exp_q.size() > 0) err_count++;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Monitor: every result takes the oldest note
  always @(negedge clk) begin
    if (cmd_valid === 1'b1) seen({4'h1, 23'h0, op});
    if (addr_valid === 1'b1 && av_q !== 1'b1) seen({4'h3, 4'h0, addr});
    if (value_valid === 1'b1) seen({4'h4, 18'h0, vidx, value});
    if ((exec | reject) === 1'b1) seen({4'h2, 26'h0, exec, reject});
    av_q = addr_valid;
  end

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    simple(16'h068E);
    check1(unlock, 1'b1);
    simple(16'h048F);
    check1(unlock, 1'b0);
    note(4'h1, 28'(OP_WRITE_UNLOCK));
    note(4'h2, 28'h1);
    cmd(CMD_WRITE_UNLOCK);
    host.shift(8'hFF, 0, 3);
    host.rel();
    check1(unlock, 1'b0);
    tdone();
    foreach (tbl[i]) simple(tbl[i]);
    pulse_done();
    check1(unlock, 1'b0);
    tdone();
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      note(4'h1, 28'(ro[i]));
      note(4'h3, {4'h0, seed[23:0]});
      cmd(rc[i]);
      addr3(seed[23:0], ra[i]);
      if (rdm[i] > 0) host.shift(8'h00, ra[i], rdm[i]);
      host.shift(seed[31:24], ra[i], 16 >> ra[i]);
      check1(out_data, 1'b1);
      check1(drive, 1'b1);
      check({30'h0, lane}, 32'(ra[i]));
      host.rel();
    end
    tdone();
    simple(16'h068E);
    seed = lfsr(seed);
    note(4'h1, 28'(OP_PAGE_WRITE));
    note(4'h3, {4'h0, seed[23:0]});
    note(4'h2, 28'h2);
    cmd(CMD_PAGE_WRITE);
    addr3(seed[23:0], 0);
    host.shift(seed[31:24], 0, 8);
    check1(in_data, 1'b1);
    host.rel();
    check1(unlock, 1'b1);
    pulse_done();
    check1(unlock, 1'b0);
    tdone();
    simple(16'h068E);
    seed = lfsr(seed);
    note(4'h1, 28'(OP_STATUS_WRITE));
    for (int v = 0; v < 3; v++) note(4'h4, {18'h0, 2'(v), seed[v * 8 +: 8]});
    note(4'h2, 28'h2);
    cmd(CMD_STATUS_WRITE);
    for (int v = 0; v < 4; v++) host.shift(seed[v * 8 +: 8], 0, 8);
    host.rel();
    pulse_done();
    seed = lfsr(seed);
    note(4'h1, 28'(OP_BURST_LENGTH));
    note(4'h4, {20'h0, seed[7:0]});
    note(4'h2, 28'h2);
    cmd(CMD_BURST_LENGTH);
    host.shift(seed[7:0], 0, 8);
    host.rel();
    check({24'h0, burst}, {24'h0, seed[7:0]});
    tdone();
    cmd(8'hFF);
    host.shift(8'h06, 0, 8);
    check1(standby, 1'b1);
    check1(drive, 1'b0);
    host.rel();
    check1(unlock, 1'b0);
    tdone();
    simple(16'h068E);
    op_busy = 1'b1;
    simple(16'hB093);
    check1(paused, 1'b1);
    check1(unlock, 1'b0);
    simple(16'h7A94);
    check1(paused, 1'b0);
    op_busy = 1'b0;
    simple(16'hB995);
    check1(sleep, 1'b1);
    tdone();
    repeat (4) @(negedge clk);
    print_verdict();
  end
endmodule : sfcd_decoder_bench

// File: sim/sfcd_host.sv
// Purpose: Serial host model driving clock, select and lanes
// Assumes: Clock idle low and still outside frames
// Notes: Each clock level lasts two system clocks
module sfcd_host (
  input wire logic i_clk,
  output logic o_sclk,
  output logic o_cs_n,
  output logic [3:0] o_sio
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle levels
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sio = 4'hA;
  end

  // Frame start
  task automatic sel();
    @(negedge i_clk);
    o_cs_n = 1'b0;
    repeat (2) @(negedge i_clk);
  endtask : sel

  // Pulses of one unit, msb on the highest lane first
  task automatic shift(input logic [7:0] b, input int lg, input int np);
    logic [7:0] s;
    logic [3:0] l;
    s = b;
    for (int p = 0; p < np; p++) begin
      l = ~o_sio;
      for (int k = 0; k < (1 << lg); k++) l[(1 << lg) - 1 - k] = s[7 - k];
      o_sio = l;
      s = s << (1 << lg);
      repeat (2) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (2) @(negedge i_clk);
      o_sclk = 1'b0;
    end
  endtask : shift

  // Frame end, lanes released to a changing level
  task automatic rel();
    o_cs_n = 1'b1;
    o_sio = ~o_sio;
    repeat (3) @(negedge i_clk);
  endtask : rel
endmodule : sfcd_host

// File: src/sfcd_decoder.sv
// Purpose: First-byte command decoder of a serial multi-lane flash
// Assumes: Serial clock, chip select and lanes synchronous to i_clk
// Notes: Array, erase engines and pin timing live elsewhere
module sfcd_decoder (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic [3:0] i_sio,
  input wire logic i_op_done,
  input wire logic i_op_busy,
  output logic o_cmd_valid,
  output sfcd_pkg::sfcd_op_e o_op,
  output logic [1:0] o_lane_log2,
  output logic o_in_data,
  output logic o_out_data,
  output logic [23:0] o_addr,
  output logic o_addr_valid,
  output logic [7:0] o_value,
  output logic o_value_valid,
  output logic [1:0] o_value_idx,
  output logic o_exec,
  output logic o_reject,
  output logic o_write_unlock_flag,
  output logic o_paused,
  output logic o_deep_sleep,
  output logic [7:0] o_burst_len,
  output logic o_sio_drive,
  output logic o_standby
);
  import sfcd_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic sfcd_op_e decode_op(input logic [7:0] code);
    unique case (code)
      CMD_READ: decode_op = OP_READ;
      CMD_FAST_READ: decode_op = OP_FAST_READ;
      CMD_DUAL_IO_READ: decode_op = OP_DUAL_IO_READ;
      CMD_DUAL_OUT_READ: decode_op = OP_DUAL_OUT_READ;
      CMD_QUAD_IO_READ: decode_op = OP_QUAD_IO_READ;
      CMD_QUAD_OUT_READ: decode_op = OP_QUAD_OUT_READ;
      CMD_PAGE_WRITE: decode_op = OP_PAGE_WRITE;
      CMD_QUAD_PAGE_WRITE: decode_op = OP_QUAD_PAGE_WRITE;
      CMD_WIPE_4K: decode_op = OP_WIPE_4K;
      CMD_WIPE_32K: decode_op = OP_WIPE_32K;
      CMD_WIPE_64K: decode_op = OP_WIPE_64K;
      CMD_WIPE_ALL_A, CMD_WIPE_ALL_B: decode_op = OP_WIPE_ALL;
      CMD_PARAM_TABLE_READ: decode_op = OP_PARAM_TABLE_READ;
      CMD_WRITE_UNLOCK: decode_op = OP_WRITE_UNLOCK;
      CMD_WRITE_LOCK: decode_op = OP_WRITE_LOCK;
      CMD_STATUS_READ: decode_op = OP_STATUS_READ;
      CMD_CONFIG_READ: decode_op = OP_CONFIG_READ;
      CMD_STATUS_WRITE: decode_op = OP_STATUS_WRITE;
      CMD_PAUSE_A, CMD_PAUSE_B: decode_op = OP_PAUSE;
      CMD_CONTINUE_A, CMD_CONTINUE_B: decode_op = OP_CONTINUE;
      CMD_DEEP_SLEEP: decode_op = OP_DEEP_SLEEP;
      CMD_BURST_LENGTH: decode_op = OP_BURST_LENGTH;
      default: decode_op = OP_NONE;
    endcase
  endfunction : decode_op

  // Lane width of address phase, log2
  function automatic logic [1:0] addr_lanes(input sfcd_op_e op);
    unique case (op)
      OP_DUAL_IO_READ: addr_lanes = 2'h1;
      OP_QUAD_IO_READ: addr_lanes = 2'h2;
      default: addr_lanes = 2'h0;
    endcase
  endfunction : addr_lanes

  // Lane width of data phase, log2
  function automatic logic [1:0] data_lanes(input sfcd_op_e op);
    unique case (op)
      OP_DUAL_IO_READ, OP_DUAL_OUT_READ: data_lanes = 2'h1;
      OP_QUAD_IO_READ, OP_QUAD_OUT_READ, OP_QUAD_PAGE_WRITE: data_lanes = 2'h2;
      default: data_lanes = 2'h0;
    endcase
  endfunction : data_lanes

  // Commands that carry a three-byte address
  function automatic logic has_addr(input sfcd_op_e op);
    unique case (op)
      OP_READ, OP_FAST_READ, OP_DUAL_IO_READ, OP_DUAL_OUT_READ, OP_QUAD_IO_READ,
      OP_QUAD_OUT_READ, OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_WIPE_4K,
      OP_WIPE_32K, OP_WIPE_64K, OP_PARAM_TABLE_READ: has_addr = 1'b1;
      default: has_addr = 1'b0;
    endcase
  endfunction : has_addr

  // Commands that need byte-aligned chip select rise
  function automatic logic is_aligned_cmd(input sfcd_op_e op);
    unique case (op)
      OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_WIPE_4K, OP_WIPE_32K, OP_WIPE_64K,
      OP_WIPE_ALL, OP_WRITE_UNLOCK, OP_WRITE_LOCK, OP_STATUS_WRITE, OP_PAUSE,
      OP_CONTINUE, OP_DEEP_SLEEP, OP_BURST_LENGTH: is_aligned_cmd = 1'b1;
      default: is_aligned_cmd = 1'b0;
    endcase
  endfunction : is_aligned_cmd

  // Commands that need the write unlock flag
  function automatic logic needs_unlock(input sfcd_op_e op);
    unique case (op)
      OP_PAGE_WRITE, OP_QUAD_PAGE_WRITE, OP_WIPE_4K, OP_WIPE_32K, OP_WIPE_64K,
      OP_WIPE_ALL, OP_STATUS_WRITE: needs_unlock = 1'b1;
      default: needs_unlock = 1'b0;
    endcase
  endfunction : needs_unlock

  // ==========================================================================
  // Edge detection of serial clock and chip select
  logic sclk_d_ff;
  logic cs_n_d_ff;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_d_ff <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= i_sclk;
      cs_n_d_ff <= i_cs_n;
    end
  end

  // Rising edge samples, falling edge drives; idle level is free
  assign sclk_rise = !i_cs_n && i_sclk && !sclk_d_ff;
  assign sclk_fall = !i_cs_n && !i_sclk && sclk_d_ff;
  assign cs_fall = cs_n_d_ff && !i_cs_n;
  assign cs_rise = !cs_n_d_ff && i_cs_n;

  // ==========================================================================
  // Shifter: lanes per edge follow the current phase width
  logic [7:0] shift_ff;
  logic [3:0] bitcnt_ff;
  logic [1:0] lane_ff;
  logic [7:0] nxt_shift;
  logic [3:0] nxt_bitcnt;
  logic byte_end;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_bitcnt = bitcnt_ff;
    unique case (lane_ff)
      2'h1: begin
        nxt_shift = {shift_ff[5:0], i_sio[1:0]};
        nxt_bitcnt = bitcnt_ff + 4'h2;
      end
      2'h2: begin
        nxt_shift = {shift_ff[3:0], i_sio[3:0]};
        nxt_bitcnt = bitcnt_ff + 4'h4;
      end
      default: begin
        nxt_shift = {shift_ff[6:0], i_sio[0]};
        nxt_bitcnt = bitcnt_ff + 4'h1;
      end
    endcase
  end

  assign byte_end = sclk_rise && (nxt_bitcnt[3]);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
    end else if (cs_fall || i_cs_n) begin
      shift_ff <= 8'h00;
      bitcnt_ff <= 4'h0;
    end else if (sclk_rise) begin
      shift_ff <= nxt_shift;
      bitcnt_ff <= byte_end ? 4'h0 : nxt_bitcnt;
    end
  end

  // ==========================================================================
  // Phase sequencer
  sfcd_phase_e phase_ff;
  sfcd_op_e op_ff;
  logic [1:0] bytecnt_ff;
  logic [2:0] dummy_ff;
  sfcd_op_e dec_op;

  assign dec_op = decode_op(nxt_shift);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_ff <= PH_IDLE;
      op_ff <= OP_NONE;
      bytecnt_ff <= 2'h0;
      dummy_ff <= 3'h0;
      lane_ff <= 2'h0;
    end else if (i_cs_n) begin
      phase_ff <= PH_IDLE;
      lane_ff <= 2'h0;
    end else if (cs_fall) begin
      phase_ff <= PH_CMD;
      op_ff <= OP_NONE;
      bytecnt_ff <= 2'h0;
      dummy_ff <= 3'h0;
      lane_ff <= 2'h0;
    end else if (sclk_rise) begin
      unique case (phase_ff)
        PH_CMD: begin
          if (byte_end) begin
            op_ff <= dec_op;
            bytecnt_ff <= 2'h0;
            if (dec_op == OP_NONE) begin
              phase_ff <= PH_REJECT;
            end else if (has_addr(dec_op)) begin
              phase_ff <= PH_ADDR;
              lane_ff <= addr_lanes(dec_op);
            end else if (dec_op == OP_STATUS_WRITE || dec_op == OP_BURST_LENGTH) begin
              phase_ff <= PH_VALUE;
            end else if (dec_op == OP_STATUS_READ || dec_op == OP_CONFIG_READ) begin
              phase_ff <= PH_DATA;
            end else begin
              phase_ff <= PH_DONE;
            end
          end
        end
        PH_ADDR: begin
          if (byte_end) begin
            bytecnt_ff <= bytecnt_ff + 2'h1;
            if (bytecnt_ff == ADDR_BYTES - 2'h1) begin
              bytecnt_ff <= 2'h0;
              if (op_ff == OP_QUAD_IO_READ) begin
                phase_ff <= PH_DUMMY;
                dummy_ff <= 3'h0;
              end else if (op_ff == OP_READ || op_ff == OP_PAGE_WRITE ||
                           op_ff == OP_QUAD_PAGE_WRITE) begin
                phase_ff <= PH_DATA;
                lane_ff <= data_lanes(op_ff);
              end else if (has_addr(op_ff) && !needs_unlock(op_ff)) begin
                phase_ff <= PH_DUMMY;
                lane_ff <= addr_lanes(op_ff);
              end else begin
                phase_ff <= PH_DONE;
              end
            end
          end
        end
        PH_DUMMY: begin
          if (op_ff == OP_QUAD_IO_READ) begin
            dummy_ff <= dummy_ff + 3'h1;
            if (dummy_ff == QUAD_DUMMY_CLKS - 3'h1) begin
              phase_ff <= PH_DATA;
            end
          end else if (byte_end) begin
            phase_ff <= PH_DATA;
            lane_ff <= data_lanes(op_ff);
          end
        end
        PH_VALUE: begin
          if (byte_end) begin
            bytecnt_ff <= bytecnt_ff + 2'h1;
            if (op_ff == OP_BURST_LENGTH ||
                bytecnt_ff == STATUS_WRITE_MAX - 2'h1) begin
              phase_ff <= PH_DONE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Captured address and values
  logic [23:0] addr_ff;
  logic addr_valid_ff;
  logic [7:0] value_ff;
  logic value_valid_ff;
  logic [1:0] value_idx_ff;
  logic cmd_valid_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_ff <= 24'h000000;
      addr_valid_ff <= 1'b0;
      value_ff <= 8'h00;
      value_valid_ff <= 1'b0;
      value_idx_ff <= 2'h0;
      cmd_valid_ff <= 1'b0;
    end else begin
      value_valid_ff <= 1'b0;
      cmd_valid_ff <= 1'b0;
      if (cs_fall) begin
        addr_valid_ff <= 1'b0;
      end
      if (sclk_rise && byte_end && phase_ff == PH_CMD && dec_op != OP_NONE) begin
        cmd_valid_ff <= 1'b1;
      end
      if (sclk_rise && byte_end && phase_ff == PH_ADDR) begin
        addr_ff <= {addr_ff[15:0], nxt_shift};
        addr_valid_ff <= (bytecnt_ff == ADDR_BYTES - 2'h1);
      end
      if (sclk_rise && byte_end && phase_ff == PH_VALUE) begin
        value_ff <= nxt_shift;
        value_valid_ff <= 1'b1;
        value_idx_ff <= bytecnt_ff;
      end
    end
  end

  // ==========================================================================
  // Byte-boundary check on chip select rise; execute or reject
  logic aligned;
  logic exec_ff;
  logic reject_ff;
  logic exec_ok;

  assign aligned = (bitcnt_ff == 4'h0) && (phase_ff == PH_DONE ||
                   (phase_ff == PH_DATA && op_ff != OP_STATUS_READ &&
                    op_ff != OP_CONFIG_READ) ||
                   (phase_ff == PH_VALUE && op_ff == OP_STATUS_WRITE &&
                    bytecnt_ff != 2'h0));
  assign exec_ok = cs_rise && is_aligned_cmd(op_ff) && aligned &&
                   (!needs_unlock(op_ff) || o_write_unlock_flag);

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      exec_ff <= 1'b0;
      reject_ff <= 1'b0;
    end else begin
      exec_ff <= exec_ok;
      reject_ff <= cs_rise && is_aligned_cmd(op_ff) && !exec_ok;
    end
  end

  // ==========================================================================
  // Write unlock flag; completion or pause clears, set wins
  logic wuf_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wuf_ff <= 1'b0;
    end else if (exec_ok && op_ff == OP_WRITE_UNLOCK) begin
      wuf_ff <= 1'b1;
    end else if (exec_ok && (op_ff == OP_WRITE_LOCK || op_ff == OP_PAUSE)) begin
      wuf_ff <= 1'b0;
    end else if (i_op_done) begin
      wuf_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Pause, sleep and burst length state
  logic paused_ff;
  logic sleep_ff;
  logic [7:0] burst_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      paused_ff <= 1'b0;
      sleep_ff <= 1'b0;
      burst_ff <= BURST_LEN_RST;
    end else begin
      if (exec_ok && op_ff == OP_PAUSE && i_op_busy) begin
        paused_ff <= 1'b1;
      end else if (exec_ok && op_ff == OP_CONTINUE) begin
        paused_ff <= 1'b0;
      end
      if (exec_ok && op_ff == OP_DEEP_SLEEP) begin
        sleep_ff <= 1'b1;
      end
      if (exec_ok && op_ff == OP_BURST_LENGTH) begin
        burst_ff <= value_ff;
      end
    end
  end

  // ==========================================================================
  // Output registers: lane drive set on falling clock, cleared on select release or leaving data phase
  logic drive_ff;
  logic in_data_ff;
  logic out_data_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      drive_ff <= 1'b0;
      in_data_ff <= 1'b0;
      out_data_ff <= 1'b0;
    end else if (i_cs_n || phase_ff != PH_DATA) begin
      drive_ff <= 1'b0;
      in_data_ff <= 1'b0;
      out_data_ff <= 1'b0;
    end else begin
      in_data_ff <= (op_ff == OP_PAGE_WRITE || op_ff == OP_QUAD_PAGE_WRITE);
      out_data_ff <= !(op_ff == OP_PAGE_WRITE || op_ff == OP_QUAD_PAGE_WRITE);
      if (sclk_fall && !(op_ff == OP_PAGE_WRITE || op_ff == OP_QUAD_PAGE_WRITE)) begin
        drive_ff <= 1'b1;
      end
    end
  end

  // Standby flag: idle or rejected frame, set from the decoded command beside the phase register
  logic standby_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      standby_ff <= 1'b1;
    end else if (i_cs_n || cs_fall) begin
      standby_ff <= i_cs_n;
    end else if (sclk_rise && byte_end && phase_ff == PH_CMD && dec_op == OP_NONE) begin
      standby_ff <= 1'b1;
    end
  end

  assign o_cmd_valid = cmd_valid_ff;
  assign o_op = op_ff;
  assign o_lane_log2 = lane_ff;
  assign o_in_data = in_data_ff;
  assign o_out_data = out_data_ff;
  assign o_addr = addr_ff;
  assign o_addr_valid = addr_valid_ff;
  assign o_value = value_ff;
  assign o_value_valid = value_valid_ff;
  assign o_value_idx = value_idx_ff;
  assign o_exec = exec_ff;
  assign o_reject = reject_ff;
  assign o_write_unlock_flag = wuf_ff;
  assign o_paused = paused_ff;
  assign o_deep_sleep = sleep_ff;
  assign o_burst_len = burst_ff;
  assign o_sio_drive = drive_ff;
  assign o_standby = standby_ff;

endmodule : sfcd_decoder
